// ---- gdio_pkg.sv ----
// package: register map, reset values and sizes of the general digital io port
package gdio_pkg;
  localparam int unsigned GDIO_WIDTH = 8;
  localparam logic [7:0] GDIO_OFS_INPUT   = 8'h00;
  localparam logic [7:0] GDIO_OFS_DIR     = 8'h04;
  localparam logic [7:0] GDIO_OFS_LATCH   = 8'h08;
  localparam logic [7:0] GDIO_OFS_CTRL    = 8'h0C;
  localparam logic [7:0] GDIO_OFS_SLEEP   = 8'h10;
  localparam int unsigned GDIO_CTRL_PUOFF_BIT = 0;
  localparam int unsigned GDIO_CTRL_DEEP_BIT  = 1;
  localparam logic [7:0] GDIO_DIR_RST    = 8'h00;
  localparam logic [7:0] GDIO_LATCH_RST  = 8'h00;
  localparam logic [7:0] GDIO_SLEEP_RST  = 8'h00;
  localparam logic [1:0] GDIO_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] GDIO_HSIZE_WORD    = 3'h2;
endpackage

// ---- gdio_pin_sync.sv ----
// per-pin input path: sleep clamp, half-cycle latch, then capture register
`timescale 1ns/1ps
module gdio_pin_sync
  import gdio_pkg::*;
#(
  parameter int unsigned WIDTH = GDIO_WIDTH
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  // pin side
  input  wire logic [WIDTH-1:0] pad_level,
  input  wire logic [WIDTH-1:0] clamp,
  // sampled value
  output logic      [WIDTH-1:0] sample
);
  logic [WIDTH-1:0] gated;
  logic [WIDTH-1:0] sync_latch;

  assign gated = pad_level & ~clamp;

  // transparent while clock high, holds while low
  always_latch begin
    if (!hresetn) begin
      sync_latch = '0;
    end else if (hclk && ce) begin
      sync_latch = gated;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample <= '0;
    end else if (ce) begin
      sample <= sync_latch;
    end
  end
endmodule

// ---- gdio_port.sv ----
// top: one eight-pin digital io port behind an ahb-lite register slave
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module gdio_port
  import gdio_pkg::*;
#(
  parameter int unsigned WIDTH = GDIO_WIDTH
) (
  // clock, reset, enable
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  // ahb-lite slave
  input  wire logic             hsel,
  input  wire logic [7:0]       haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic      [WIDTH-1:0] pin_pullup,
  // external interrupt enables per pin, keep input alive in deep sleep
  input  wire logic [WIDTH-1:0] ext_int_en
);
  logic [WIDTH-1:0] direction_register;
  logic [WIDTH-1:0] output_latch_register;
  logic [WIDTH-1:0] input_sample_register;
  logic [WIDTH-1:0] ext_int_keep;
  logic             global_pullup_off;
  logic             deep_sleep;
  logic             wr_pend;
  logic [7:0]       wr_addr;
  logic             take;
  logic [WIDTH-1:0] clamp;
  logic [WIDTH-1:0] wdat;

  function automatic logic [WIDTH-1:0] pick(input logic [31:0] d);
    pick = d[WIDTH-1:0];
  endfunction

  assign take = hsel && hready && (htrans == GDIO_HTRANS_NONSEQ) && (hsize == GDIO_HSIZE_WORD);
  assign wdat = pick(hwdata);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (ce) begin
      wr_pend <= take && hwrite;
      if (take) begin
        wr_addr <= haddr;
      end
    end
  end

  // direction register, whole-word write replaces all eight bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      direction_register <= GDIO_DIR_RST;
    end else if (ce && wr_pend && wr_addr == GDIO_OFS_DIR) begin
      direction_register <= wdat;
    end
  end

  // output latch: direct write or toggle through input register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_latch_register <= GDIO_LATCH_RST;
    end else if (ce && wr_pend) begin
      if (wr_addr == GDIO_OFS_LATCH) begin
        output_latch_register <= wdat;
      end else if (wr_addr == GDIO_OFS_INPUT) begin
        output_latch_register <= output_latch_register ^ wdat;
      end
    end
  end

  // control: pull-up off and deep sleep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_pullup_off <= 1'b0;
      deep_sleep        <= 1'b0;
    end else if (ce && wr_pend && wr_addr == GDIO_OFS_CTRL) begin
      global_pullup_off <= hwdata[GDIO_CTRL_PUOFF_BIT];
      deep_sleep        <= hwdata[GDIO_CTRL_DEEP_BIT];
    end
  end

  // software mirror of interrupt enable mask, or-ed with the port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_int_keep <= GDIO_SLEEP_RST;
    end else if (ce && wr_pend && wr_addr == GDIO_OFS_SLEEP) begin
      ext_int_keep <= wdat;
    end
  end

  assign clamp = deep_sleep ? ~(ext_int_keep | ext_int_en) : '0;

  // pad drive: tri-state in reset through async reset of the registers
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pad
      assign pin_oe[i]     = direction_register[i];
      assign pin_out[i]    = direction_register[i] & output_latch_register[i];
      assign pin_pullup[i] = !direction_register[i] && output_latch_register[i]
                             && !global_pullup_off;
    end
  endgenerate

  // the pad level seen is the pin itself; when driving, the pin follows
  // the latch, so a write shows one clock later
  gdio_pin_sync #(
    .WIDTH (WIDTH)
  ) u_sync (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .pad_level (pin_in),
    .clamp     (clamp),
    .sample    (input_sample_register)
  );

  // read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && take && !hwrite) begin
      unique case (haddr)
        GDIO_OFS_INPUT: hrdata <= {24'h000000, input_sample_register};
        GDIO_OFS_DIR:   hrdata <= {24'h000000, direction_register};
        GDIO_OFS_LATCH: hrdata <= {24'h000000, output_latch_register};
        GDIO_OFS_CTRL:  hrdata <= {30'h0, deep_sleep, global_pullup_off};
        GDIO_OFS_SLEEP: hrdata <= {24'h000000, ext_int_keep};
        default:        hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ---- gdio_port_assertions.sv ----
// checker: pin and bus relations seen at the io port boundary
`timescale 1ns/1ps
module gdio_chk
  import gdio_pkg::*;
(
  // clock, reset and bus
  input wire logic        hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  // pins
  input wire logic [7:0]  pin_out, pin_oe, pin_pullup
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       wr;
  logic [7:0] wd;
  assign wr = hsel & hready & ce & hwrite & htrans == GDIO_HTRANS_NONSEQ & hsize == GDIO_HSIZE_WORD;
  assign wd = hwdata[7:0];
  AST_READY: assert property (hreadyout) else $error("hreadyout low");
  AST_OKAY: assert property (!hresp) else $error("error response");
  AST_RST: assert property ($rose(hresetn) |-> pin_oe == 8'h00 && pin_pullup == 8'h00)
    else $error("pins active after reset");
  AST_DRV: assert property ((pin_out & ~pin_oe) == 8'h00) else $error("undriven pin high");
  AST_PU: assert property ((pin_pullup & pin_oe) == 8'h00) else $error("pull-up on output");
  AST_DIR: assert property (wr && haddr == GDIO_OFS_DIR ##1 1 |=> pin_oe == $past(wd))
    else $error("direction not applied");
  AST_LAT: assert property (wr && haddr == GDIO_OFS_LATCH ##1 1 |=> pin_out == ($past(wd) & pin_oe))
    else $error("drive value wrong");
  AST_TOG: assert property (wr && haddr == GDIO_OFS_INPUT ##1 1 |=>
    pin_out == ($past(pin_out) ^ ($past(wd) & pin_oe))) else $error("toggle wrong");
  AST_PUD: assert property (wr && haddr == GDIO_OFS_CTRL ##1 hwdata[0] |=> pin_pullup == 8'h00)
    else $error("pull-up not disabled");
endmodule
bind gdio_port gdio_chk u_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .haddr(haddr),
  .htrans(htrans), .hsize(hsize), .hwdata(hwdata), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pullup(pin_pullup));

// ---- gdio_pad_model.sv ----
// pad model: external circuitry on the port pins
`timescale 1ns/1ps
module gdio_pad_model (
  // clock and bench drive
  input wire logic       hclk, ext_drv,
  input wire logic [7:0] ext_val, pin_out, pin_oe, pin_pullup,
  // pad level
  output logic     [7:0] pin_in
);
  logic [7:0] noise = 8'h5A;
  // floating pins wander so no stale level passes by chance
  always @(posedge hclk) noise <= ~noise;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & (ext_drv ? ext_val : pin_pullup | noise));
endmodule

// ---- gdio_tb.sv ----
// bench: ahb-lite master, pad model and read scoreboard for the io port
`timescale 1ns/1ps
module tb;
  import gdio_pkg::*;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, rd = 1'h0;
  logic [7:0]  haddr = 8'h00, ev = 8'h00, xi = 8'h00, pin_in, pin_out, pin_oe, pin_pullup;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q[$];
  logic        hreadyout, hresp;
  logic [15:0] r = 16'h32A5;
  int          errors = 0, compares = 0;
  gdio_port u_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .ext_int_en(xi));
  gdio_pad_model u_pad (.hclk(hclk), .ext_drv(1'h1), .ext_val(ev), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_in(pin_in));
  initial forever #25 hclk = ~hclk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic rdy();
    for (int i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'h1) return;
    end
    errors++;
    print_verdict();
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    hsel <= 1'h1;
    htrans <= GDIO_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= GDIO_HSIZE_WORD;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) q.push_back(e);
    rd <= !w;
    rdy();
    rd <= 1'h0;
  endtask
  // scoreboard: oldest note against each read
  always @(posedge hclk) if (rd) chk("hrdata", hrdata, q.pop_front());
  initial begin
    logic [7:0] d, l, t, p;
    repeat (2) @(posedge hclk);
    chk("oe", pin_oe, 32'h0);
    chk("pu", pin_pullup, 32'h0);
    hresetn <= 1'h1;
    @(posedge hclk);
    xf(0, GDIO_OFS_DIR, 32'h0, GDIO_DIR_RST);
    xf(0, GDIO_OFS_LATCH, 32'h0, GDIO_LATCH_RST);
    xf(1, 8'h20, 32'hFF, 32'h0);
    xf(0, 8'h20, 32'h0, 32'h0);
    for (int k = 0; k < 6; k++) begin
      r = lfsr(r);
      d = r[7:0];
      l = r[15:8];
      r = lfsr(r);
      t = r[7:0];
      ev <= r[15:8];
      xi <= t;
      // latch then direction: each write sets all eight bits of one register
      xf(1, GDIO_OFS_LATCH, {24'h0, l}, 32'h0);
      xf(1, GDIO_OFS_DIR, {24'h0, d}, 32'h0);
      #1;
      chk("oe", pin_oe, d);
      chk("out", pin_out, d & l);
      chk("pu", pin_pullup, ~d & l);
      xf(1, GDIO_OFS_CTRL, 32'h1, 32'h0);
      #1;
      chk("pud", pin_pullup, 32'h0);
      xf(1, GDIO_OFS_CTRL, 32'h0, 32'h0);
      xf(1, GDIO_OFS_INPUT, {24'h0, t}, 32'h0);
      xf(0, GDIO_OFS_LATCH, 32'h0, l ^ t);
      p = (d & (l ^ t)) | (~d & ev);
      // idle cycle before reading back
      @(posedge hclk);
      xf(0, GDIO_OFS_INPUT, 32'h0, p);
      xf(1, GDIO_OFS_SLEEP, {24'h0, d}, 32'h0);
      xf(1, GDIO_OFS_CTRL, 32'h2, 32'h0);
      @(posedge hclk);
      xf(0, GDIO_OFS_INPUT, 32'h0, p & (t | d));
      xf(1, GDIO_OFS_CTRL, 32'h0, 32'h0);
      $display("test %0d done", k);
    end
    // second reset in mid-run with pins driving
    xf(1, GDIO_OFS_LATCH, 32'hFF, 32'h0);
    xf(1, GDIO_OFS_DIR, 32'hF0, 32'h0);
    hresetn <= 1'h0;
    @(posedge hclk);
    #1;
    chk("oe_rst", pin_oe, 32'h0);
    chk("pu_rst", pin_pullup, 32'h0);
    hresetn <= 1'h1;
    @(posedge hclk);
    xf(0, GDIO_OFS_DIR, 32'h0, GDIO_DIR_RST);
    xf(0, GDIO_OFS_LATCH, 32'h0, GDIO_LATCH_RST);
    $display("test reset done");
    print_verdict();
  end
endmodule
